// ==== design/hssc_top.sv ====
// Purpose: high-side lamp driver and aux 5 V output control with fault flags
// Assumes: fault and pwm inputs arrive asynchronously from the analogue side
// Notes: registers reached over classic wishbone, one-cycle-late ack
// Operation
// - every high-side output stays off unless power_stage_enable is set.
// - no pwm select: off without force_on; force_on holds on, overcurrent flags and trips off.
// - pwm select without force_on: channel follows the pwm input level.
// - pwm mode overcurrent turns channel off, sets flag, next pwm rise turns on.
// - pwm select plus force_on: channel on with inrush current limitation active.
// - limitation mode overcurrent sets the overcurrent flag and turns the channel off until the next pwm rise.
// - during limitation each pwm rise re-enables the driver, duty has no effect.
// - voltage fault flags disable high-sides unless voltage_shutdown_disable is set.
// - write 1 clears voltage flags and re-enables, no effect while fault persists.
// - over-temperature warning sets overtemp_flag and interrupts when enabled.
// - enabled over-temperature shutdown turns off high-sides and half-bridge high FETs.
// - write 1 clears overtemp_flag, no effect while condition persists; reset clears.
// - with shutdown disabled, hard threshold turns off every power stage.
// - aux 5 V on only with power_stage_enable and aux_supply_on; voltage flags ignored.
// - aux overcurrent limits current and sets aux_supply_overcurrent_flag.
// - write 1 clears a channel overcurrent flag and re-enables it; 0 does nothing.
// - write 1 clears aux overcurrent flag and re-enables aux; 0 does nothing.
// - reset clears force_on, pwm_select and aux_supply_on bits.
// - hs over-temperature shutdown bit 1 disables auto shutdown, 0 enables; reset clears.
// - voltage_shutdown_disable 1 disables voltage shutdown, 0 enables; reset clears.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hssc_top #(
    parameter int N_HS = 3,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pwm_i,
    input wire logic [N_HS-1:0] hs_oc_i,
    input wire logic aux_oc_i,
    input wire logic low_volt_i,
    input wire logic high_volt_i,
    input wire logic overtemp_warning_i,
    input wire logic overtemp_hard_threshold_i,
    output logic [N_HS-1:0] hs_on_o,
    output logic [N_HS-1:0] hs_limit_o,
    output logic aux_5v_output_o,
    output logic aux_limit_o,
    output logic hb_high_off_o,
    output logic hb_low_off_o,
    output logic all_stages_off_o,
    output logic overtemp_irq_o
);
    localparam int NIN = N_HS + 6;

    if (N_HS < 1 || N_HS > hssc_pkg::MAX_HS || ADDR_W < 8)
    begin : g_bad_param
        $error("hssc_top: N_HS must be 1..3 and ADDR_W at least 8");
    end

    // input synchronisers
    logic [NIN-1:0] async_in;
    logic [NIN-1:0] sync1_ff;
    logic [NIN-1:0] sync2_ff;
    logic pwm_d_ff;
    logic pwm_s;
    logic pwm_rise;
    logic [N_HS-1:0] oc_s;
    logic aux_oc_s;
    logic lv_s;
    logic hv_s;
    logic otw_s;
    logic oth_s;

    assign async_in = {pwm_i, aux_oc_i, low_volt_i, high_volt_i,
                       overtemp_warning_i, overtemp_hard_threshold_i, hs_oc_i};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
        end
    end

    assign oc_s = sync2_ff[N_HS-1:0];
    assign oth_s = sync2_ff[N_HS];
    assign otw_s = sync2_ff[N_HS+1];
    assign hv_s = sync2_ff[N_HS+2];
    assign lv_s = sync2_ff[N_HS+3];
    assign aux_oc_s = sync2_ff[N_HS+4];
    assign pwm_s = sync2_ff[N_HS+5];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pwm_d_ff <= 1'b0;
        end
        else
        begin
            pwm_d_ff <= pwm_s;
        end
    end

    assign pwm_rise = pwm_s & ~pwm_d_ff;

    // wishbone slave
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic req;
    logic wr_fire;
    logic [5:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;

    assign req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[7:2];
    assign wbyte = wb_dat_i[7:0];
    assign wr_fire = req & wb_we_i & ack_ff & wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // control registers
    logic pse_ff;
    logic ls_ot_dis_ff;
    logic hs_ot_dis_ff;
    logic vsd_ff;
    logic [N_HS-1:0] force_ff;
    logic [N_HS-1:0] pwmsel_ff;
    logic aux_on_ff;
    logic ot_irq_en_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pse_ff <= 1'b0;
            ls_ot_dis_ff <= 1'b0;
            hs_ot_dis_ff <= 1'b0;
            vsd_ff <= 1'b0;
        end
        else if (wr_fire && idx == hssc_pkg::IDX_SYSTEM_CONTROL)
        begin
            pse_ff <= wbyte[hssc_pkg::PSE_BIT];
            ls_ot_dis_ff <= wbyte[hssc_pkg::LS_OT_DIS_BIT];
            hs_ot_dis_ff <= wbyte[hssc_pkg::HS_OT_DIS_BIT];
            vsd_ff <= wbyte[hssc_pkg::VSD_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            force_ff <= '0;
            pwmsel_ff <= '0;
            aux_on_ff <= 1'b0;
        end
        else if (wr_fire && idx == hssc_pkg::IDX_HS_OUTPUT_CONTROL)
        begin
            force_ff <= wbyte[hssc_pkg::FORCE_LSB +: N_HS];
            pwmsel_ff <= wbyte[hssc_pkg::PWM_LSB +: N_HS];
            aux_on_ff <= wbyte[hssc_pkg::AUX_ON_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ot_irq_en_ff <= 1'b0;
        end
        else if (wr_fire && idx == hssc_pkg::IDX_IRQ_MASK)
        begin
            ot_irq_en_ff <= wbyte[hssc_pkg::OT_BIT];
        end
    end

    // write-one-to-clear strobes
    logic fs_wr;
    logic fl_wr;
    logic [N_HS-1:0] oc_clr;
    logic aux_clr;
    logic lv_clr;
    logic hv_clr;
    logic ot_clr;

    assign fs_wr = wr_fire && idx == hssc_pkg::IDX_HS_FAULT_STATUS;
    assign fl_wr = wr_fire && idx == hssc_pkg::IDX_IRQ_FLAG;
    assign oc_clr = fs_wr ? wbyte[hssc_pkg::HS_OCF_LSB +: N_HS] : '0;
    assign aux_clr = fs_wr & wbyte[hssc_pkg::AUX_OCF_BIT];
    assign lv_clr = fl_wr & wbyte[hssc_pkg::LV_BIT];
    assign hv_clr = fl_wr & wbyte[hssc_pkg::HV_BIT];
    assign ot_clr = fl_wr & wbyte[hssc_pkg::OT_BIT];

    // supply and temperature flags; a set wins over a clear
    logic lv_flag_ff;
    logic hv_flag_ff;
    logic ot_flag_ff;
    logic aux_ocf_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lv_flag_ff <= 1'b0;
            hv_flag_ff <= 1'b0;
            ot_flag_ff <= 1'b0;
            aux_ocf_ff <= 1'b0;
        end
        else
        begin
            lv_flag_ff <= lv_s | (lv_flag_ff & ~lv_clr);
            hv_flag_ff <= hv_s | (hv_flag_ff & ~hv_clr);
            ot_flag_ff <= otw_s | (ot_flag_ff & ~ot_clr);
            aux_ocf_ff <= (aux_oc_s & aux_5v_output_o) | (aux_ocf_ff & ~aux_clr);
        end
    end

    // global gating
    logic volt_shut;
    logic temp_shut;
    logic hard_shut;
    logic hs_allow;

    assign volt_shut = (lv_flag_ff | hv_flag_ff) & ~vsd_ff;
    assign temp_shut = ot_flag_ff & ~hs_ot_dis_ff;
    assign hard_shut = oth_s & hs_ot_dis_ff;
    assign hs_allow = pse_ff & ~volt_shut & ~temp_shut & ~hard_shut;

    // per-channel switch logic
    logic [N_HS-1:0] ocf_ff;
    logic [N_HS-1:0] trip_ff;
    logic [N_HS-1:0] nxt_on;

    for (genvar c = 0; c < N_HS; c++)
    begin : g_ch
        logic oc_evt;

        assign oc_evt = oc_s[c] & hs_on_o[c];

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                ocf_ff[c] <= 1'b0;
            end
            else
            begin
                ocf_ff[c] <= oc_evt | (ocf_ff[c] & ~oc_clr[c]);
            end
        end

        // pulse trip, cleared by the next pwm rise
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                trip_ff[c] <= 1'b0;
            end
            else if (!pwmsel_ff[c])
            begin
                trip_ff[c] <= 1'b0;
            end
            else if (pwm_rise)
            begin
                trip_ff[c] <= 1'b0;
            end
            else if (oc_evt)
            begin
                trip_ff[c] <= 1'b1;
            end
        end

        always_comb
        begin
            case ({pwmsel_ff[c], force_ff[c]})
                2'b00: nxt_on[c] = 1'b0;
                2'b01: nxt_on[c] = ~ocf_ff[c] & ~oc_evt;
                2'b10: nxt_on[c] = pwm_s & ~trip_ff[c] & ~oc_evt;
                2'b11: nxt_on[c] = ~trip_ff[c] & ~oc_evt;
                default: nxt_on[c] = 1'b0;
            endcase
        end
    end

    // output registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hs_on_o <= '0;
            hs_limit_o <= '0;
            aux_5v_output_o <= 1'b0;
            aux_limit_o <= 1'b0;
            hb_high_off_o <= 1'b0;
            hb_low_off_o <= 1'b0;
            all_stages_off_o <= 1'b0;
            overtemp_irq_o <= 1'b0;
        end
        else
        begin
            hs_on_o <= nxt_on & {N_HS{hs_allow}};
            hs_limit_o <= pwmsel_ff & force_ff & {N_HS{hs_allow}};
            aux_5v_output_o <= pse_ff & aux_on_ff & ~hard_shut;
            aux_limit_o <= aux_oc_s & aux_5v_output_o;
            hb_high_off_o <= temp_shut | hard_shut;
            hb_low_off_o <= (ot_flag_ff & ~ls_ot_dis_ff) | hard_shut;
            all_stages_off_o <= hard_shut;
            overtemp_irq_o <= ot_flag_ff & ot_irq_en_ff;
        end
    end

    // read path
    always_comb
    begin
        rd_mux = 8'h00;
        case (idx)
            hssc_pkg::IDX_SYSTEM_CONTROL:
            begin
                rd_mux[hssc_pkg::PSE_BIT] = pse_ff;
                rd_mux[hssc_pkg::LS_OT_DIS_BIT] = ls_ot_dis_ff;
                rd_mux[hssc_pkg::HS_OT_DIS_BIT] = hs_ot_dis_ff;
                rd_mux[hssc_pkg::VSD_BIT] = vsd_ff;
            end
            hssc_pkg::IDX_HS_OUTPUT_CONTROL:
            begin
                rd_mux[hssc_pkg::FORCE_LSB +: N_HS] = force_ff;
                rd_mux[hssc_pkg::PWM_LSB +: N_HS] = pwmsel_ff;
                rd_mux[hssc_pkg::AUX_ON_BIT] = aux_on_ff;
            end
            hssc_pkg::IDX_HS_FAULT_STATUS:
            begin
                rd_mux[hssc_pkg::HS_OCF_LSB +: N_HS] = ocf_ff;
                rd_mux[hssc_pkg::AUX_OCF_BIT] = aux_ocf_ff;
            end
            hssc_pkg::IDX_IRQ_FLAG:
            begin
                rd_mux[hssc_pkg::LV_BIT] = lv_flag_ff;
                rd_mux[hssc_pkg::HV_BIT] = hv_flag_ff;
                rd_mux[hssc_pkg::OT_BIT] = ot_flag_ff;
            end
            hssc_pkg::IDX_IRQ_MASK:
            begin
                rd_mux[hssc_pkg::OT_BIT] = ot_irq_en_ff;
            end
            default:
            begin
                rd_mux = hssc_pkg::REG_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_ff <= '0;
        end
        else if (req && !ack_ff)
        begin
            rdat_ff <= {24'h000000, rd_mux};
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
endmodule // hssc_top
`default_nettype wire

// ==== inc/hssc_pkg.sv ====
// Purpose: shared constants for the high-side switch control block
// Assumes: 32-bit classic wishbone, one aligned word per register
// Notes: byte address of a register is four times its index
package hssc_pkg;
    // register indices
    localparam logic [5:0] IDX_SYSTEM_CONTROL = 6'h00;
    localparam logic [5:0] IDX_HS_OUTPUT_CONTROL = 6'h02;
    localparam logic [5:0] IDX_HS_FAULT_STATUS = 6'h04;
    localparam logic [5:0] IDX_IRQ_FLAG = 6'h05;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h06;
    // system_control fields
    localparam int PSE_BIT = 7;
    localparam int LS_OT_DIS_BIT = 4;
    localparam int HS_OT_DIS_BIT = 3;
    localparam int VSD_BIT = 2;
    // high_side_output_control fields
    localparam int FORCE_LSB = 0;
    localparam int PWM_LSB = 3;
    localparam int AUX_ON_BIT = 6;
    // high_side_fault_status fields
    localparam int HS_OCF_LSB = 0;
    localparam int AUX_OCF_BIT = 3;
    // irq flag and mask fields
    localparam int LV_BIT = 0;
    localparam int HV_BIT = 1;
    localparam int OT_BIT = 2;
    // reset value, channel limit and synchroniser depth
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int MAX_HS = 3;
    localparam int SYNC_STAGES = 2;
endpackage

// ==== tb/hssc_load.sv ====
// Purpose: lamp loads and pwm source beside hssc_top
// Assumes: bench commands shorts and pwm style
// Notes: overcurrent shows only while a stage is on
`timescale 1ns/1ps
`default_nettype none
module hssc_load (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic lvl_i,
    input wire logic [2:0] short_i,
    input wire logic aux_short_i,
    input wire logic [2:0] hs_on_i,
    input wire logic aux_on_i,
    output logic pwm_o,
    output logic [2:0] hs_oc_o,
    output logic aux_oc_o
);
    logic [3:0] cnt = 4'h0;
    always @(posedge clk_i)
    begin
        cnt <= cnt + 4'h1;
        pwm_o <= run_i ? cnt[3] : lvl_i;
        hs_oc_o <= hs_on_i & short_i;
        aux_oc_o <= aux_on_i & aux_short_i;
    end
endmodule // hssc_load
`default_nettype wire

// ==== tb/hssc_sva.sv ====
// Purpose: port checker for hssc_top
// Assumes: writes land at the ack edge
// Notes: control bits are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module hssc_sva #(
    parameter int N_HS = 3,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic low_volt_i,
    input wire logic high_volt_i,
    input wire logic overtemp_warning_i,
    input wire logic overtemp_hard_threshold_i,
    input wire logic [N_HS-1:0] hs_on_o,
    input wire logic [N_HS-1:0] hs_limit_o,
    input wire logic aux_5v_output_o,
    input wire logic hb_high_off_o,
    input wire logic all_stages_off_o,
    input wire logic overtemp_irq_o
);
    logic [7:0] sys_ff;
    logic [7:0] ctl_ff;
    logic msk_ff;
    logic wr;
    logic [5:0] idx;
    logic [N_HS-1:0] mode_on;
    assign idx = wb_adr_i[7:2];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign mode_on = ctl_ff[N_HS-1:0] | ctl_ff[hssc_pkg::PWM_LSB +: N_HS];
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sys_ff <= 8'h00;
            ctl_ff <= 8'h00;
            msk_ff <= 1'b0;
        end
        else if (wr)
        begin
            if (idx == hssc_pkg::IDX_SYSTEM_CONTROL)
                sys_ff <= wb_dat_i[7:0];
            if (idx == hssc_pkg::IDX_HS_OUTPUT_CONTROL)
                ctl_ff <= wb_dat_i[7:0];
            if (idx == hssc_pkg::IDX_IRQ_MASK)
                msk_ff <= wb_dat_i[2];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_ANS: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    AST_RD_HI: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_PSE_GATE: assert property (hs_on_o != '0 |-> $past(sys_ff[7]))
        else $error("channel on without power stage enable");
    AST_MODE_OFF: assert property ((hs_on_o & ~$past(mode_on)) == '0)
        else $error("channel on with no mode bit");
    AST_AUX_GATE: assert property (aux_5v_output_o |-> $past(sys_ff[7]) && $past(ctl_ff[6]))
        else $error("aux output on without both enables");
    AST_VOLT_OFF: assert property (((low_volt_i || high_volt_i) && !sys_ff[2])[*8] |-> hs_on_o == '0)
        else $error("channel on during voltage fault");
    AST_OT_OFF: assert property ((overtemp_warning_i && !sys_ff[3])[*8] |-> hs_on_o == '0 && hb_high_off_o)
        else $error("high sides on during overtemp warning");
    AST_HARD_OFF: assert property ((overtemp_hard_threshold_i && sys_ff[3])[*8]
        |-> all_stages_off_o && !aux_5v_output_o && hs_on_o == '0)
        else $error("stages on above hard threshold");
    AST_IRQ_MASK: assert property (overtemp_irq_o |-> $past(msk_ff))
        else $error("overtemp irq while masked");
    cover property (hs_limit_o != '0);
    cover property (overtemp_irq_o);
    cover property (all_stages_off_o);
endmodule // hssc_sva
bind hssc_top hssc_sva #(.N_HS(N_HS), .ADDR_W(ADDR_W)) i_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .low_volt_i(low_volt_i), .high_volt_i(high_volt_i), .overtemp_warning_i(overtemp_warning_i),
    .overtemp_hard_threshold_i(overtemp_hard_threshold_i), .hs_on_o(hs_on_o), .hs_limit_o(hs_limit_o),
    .aux_5v_output_o(aux_5v_output_o), .hb_high_off_o(hb_high_off_o), .all_stages_off_o(all_stages_off_o),
    .overtemp_irq_o(overtemp_irq_o)
);
`default_nettype wire

// ==== tb/hssc_test.sv ====
// Purpose: self-checking bench for hssc_top
// Assumes: one 8-bit register per wishbone word
// Notes: fault levels settle within eight cycles
`timescale 1ns/1ps
`default_nettype none
module hssc_test;
    localparam logic [5:0] SYS = hssc_pkg::IDX_SYSTEM_CONTROL;
    localparam logic [5:0] CTL = hssc_pkg::IDX_HS_OUTPUT_CONTROL;
    localparam logic [5:0] STA = hssc_pkg::IDX_HS_FAULT_STATUS;
    localparam logic [5:0] IFL = hssc_pkg::IDX_IRQ_FLAG;
    localparam logic [5:0] MSK = hssc_pkg::IDX_IRQ_MASK;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h1;
    logic [3:0] bsel = 4'h1;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic run = 1'b0;
    logic lvl = 1'b0;
    logic ash = 1'b0;
    logic [2:0] sh = 3'h0;
    logic lv = 1'b0;
    logic hv = 1'b0;
    logic otw = 1'b0;
    logic oth = 1'b0;
    logic [31:0] dat;
    logic ack, pwm, aux_oc, aux, aux_lim, hb_hi, hb_lo, all_off, irq;
    logic [2:0] hs_oc, hs_on, hs_lim;
    int num_errors = 0;
    int checks = 0;
    always #2.5 clk_i = ~clk_i;
    hssc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .pwm_i(pwm),
        .hs_oc_i(hs_oc), .aux_oc_i(aux_oc), .low_volt_i(lv), .high_volt_i(hv), .overtemp_warning_i(otw),
        .overtemp_hard_threshold_i(oth), .hs_on_o(hs_on), .hs_limit_o(hs_lim), .aux_5v_output_o(aux),
        .aux_limit_o(aux_lim), .hb_high_off_o(hb_hi), .hb_low_off_o(hb_lo), .all_stages_off_o(all_off),
        .overtemp_irq_o(irq));
    hssc_load i_load (.clk_i(clk_i), .run_i(run), .lvl_i(lvl), .short_i(sh), .aux_short_i(ash),
        .hs_on_i(hs_on), .aux_on_i(aux), .pwm_o(pwm), .hs_oc_o(hs_oc), .aux_oc_o(aux_oc));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        sel <= bsel;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat;
        cyc <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string n);
        bus(1'b0, idx, 8'h00);
        chk(n, rdat, {24'h0, e});
    endtask
    task automatic nap();
        repeat (8) @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SYS, 8'h00, "sys");
        rd(CTL, 8'h00, "ctl");
        rd(STA, 8'h00, "sta");
        rd(IFL, 8'h00, "ifl");
        rd(6'h3f, 8'h00, "unmapped");
        bsel = 4'he;
        bus(1'b1, SYS, 8'h80);
        bsel = 4'h1;
        rd(SYS, 8'h00, "sel0");
        bus(1'b1, CTL, 8'h47);
        nap();
        chk("pse off", hs_on, 3'h0);
        chk("aux pse off", aux, 1'b0);
        bus(1'b1, SYS, 8'h80);
        nap();
        chk("force", hs_on, 3'h7);
        chk("aux on", aux, 1'b1);
        $display("test gate finished");
        sh <= 3'h1;
        nap();
        sh <= 3'h0;
        nap();
        chk("trip", hs_on, 3'h6);
        bus(1'b1, STA, 8'h00);
        rd(STA, 8'h01, "w0");
        bus(1'b1, STA, 8'h01);
        nap();
        rd(STA, 8'h00, "w1");
        chk("reon", hs_on, 3'h7);
        $display("test force finished");
        bus(1'b1, CTL, 8'h51);
        nap();
        chk("pwm lo", hs_on, 3'h1);
        lvl <= 1'b1;
        nap();
        chk("pwm hi", hs_on, 3'h3);
        sh <= 3'h2;
        nap();
        sh <= 3'h0;
        nap();
        chk("pwm trip", hs_on, 3'h1);
        rd(STA, 8'h02, "pwm flag");
        lvl <= 1'b0;
        nap();
        lvl <= 1'b1;
        nap();
        chk("pwm rise", hs_on, 3'h3);
        bus(1'b1, STA, 8'h02);
        $display("test pwm finished");
        bus(1'b1, CTL, 8'h64);
        nap();
        chk("lim", hs_lim, 3'h4);
        chk("lim on", hs_on, 3'h4);
        run <= 1'b1;
        sh <= 3'h4;
        repeat (40) @(posedge clk_i);
        rd(STA, 8'h04, "lim flag");
        sh <= 3'h0;
        for (int i = 0; i < 48 && hs_on[2] !== 1'b1; i++) @(posedge clk_i);
        chk("lim back", hs_on[2], 1'b1);
        run <= 1'b0;
        bus(1'b1, STA, 8'h04);
        $display("test limit finished");
        bus(1'b1, CTL, 8'h47);
        ash <= 1'b1;
        nap();
        rd(STA, 8'h08, "aux flag");
        chk("aux lim", aux_lim, 1'b1);
        ash <= 1'b0;
        nap();
        bus(1'b1, STA, 8'h08);
        nap();
        rd(STA, 8'h00, "aux clr");
        chk("aux back", aux, 1'b1);
        $display("test aux finished");
        lv <= 1'b1;
        nap();
        chk("lv off", hs_on, 3'h0);
        chk("lv aux", aux, 1'b1);
        bus(1'b1, IFL, 8'h01);
        rd(IFL, 8'h01, "lv stays");
        lv <= 1'b0;
        nap();
        chk("lv held", hs_on, 3'h0);
        bus(1'b1, IFL, 8'h01);
        nap();
        chk("lv clr", hs_on, 3'h7);
        bus(1'b1, SYS, 8'h84);
        hv <= 1'b1;
        nap();
        chk("vsd", hs_on, 3'h7);
        hv <= 1'b0;
        bus(1'b1, IFL, 8'h02);
        bus(1'b1, SYS, 8'h80);
        $display("test volt finished");
        bus(1'b1, MSK, 8'h04);
        otw <= 1'b1;
        nap();
        chk("irq", irq, 1'b1);
        chk("ot off", hs_on, 3'h0);
        chk("hb hi", hb_hi, 1'b1);
        bus(1'b1, IFL, 8'h04);
        rd(IFL, 8'h04, "ot stays");
        bus(1'b1, MSK, 8'h00);
        nap();
        chk("irq mask", irq, 1'b0);
        otw <= 1'b0;
        nap();
        bus(1'b1, IFL, 8'h04);
        nap();
        chk("ot clr", hs_on, 3'h7);
        chk("lo clr", hb_lo, 1'b0);
        bus(1'b1, SYS, 8'h88);
        otw <= 1'b1;
        nap();
        chk("htd", hs_on, 3'h7);
        oth <= 1'b1;
        nap();
        chk("hard", all_off, 1'b1);
        chk("hard aux", aux, 1'b0);
        chk("hard hs", hs_on, 3'h0);
        chk("hard lo", hb_lo, 1'b1);
        nap();
        $display("test temp finished");
        complete_run();
    end
endmodule // hssc_test
`default_nettype wire
